// >>> dv/rwm_link_checker.sv
// Concurrent checks on the remote word link between controller and driver
module rwm_link_checker
(
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic [15:0] first_monitor_code,
  input wire logic [15:0] second_monitor_code,
  input wire logic [15:0] instruction_select,
  input wire logic [15:0] write_value,
  input wire logic        monitor_request_bit,
  input wire logic        instruction_request_bit,
  input wire logic [15:0] monitor_result_word0,
  input wire logic [15:0] monitor_result_word1,
  input wire logic [15:0] response_status,
  input wire logic [15:0] read_value,
  input wire logic [15:0] second_monitor_low_half,
  input wire logic [15:0] second_monitor_high_half,
  input wire logic        monitor_valid_bit,
  input wire logic        instruction_complete_bit
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Handshake bits only answer a live request
  property p_mv_cause; $rose(monitor_valid_bit) |-> monitor_request_bit; endproperty
  property p_mv_hold; monitor_valid_bit && monitor_request_bit |=> monitor_valid_bit; endproperty
  property p_mv_drop; monitor_valid_bit && !monitor_request_bit |=> !monitor_valid_bit; endproperty
  property p_ic_cause; $rose(instruction_complete_bit) |-> instruction_request_bit; endproperty
  property p_ic_drop; instruction_complete_bit && !instruction_request_bit |=> !instruction_complete_bit;
  endproperty
  // Bounded answer time; the bench source acks within a few cycles
  property p_mv_time; $rose(monitor_request_bit) |-> ##[2:40] monitor_valid_bit; endproperty
  property p_ic_time; $rose(instruction_request_bit) |-> ##[2:40] instruction_complete_bit; endproperty
  // Result words are loaded with valid and then stand still
  property p_mv_words;
    monitor_valid_bit && $past(monitor_valid_bit) |-> $stable({monitor_result_word0, monitor_result_word1,
      second_monitor_low_half, second_monitor_high_half});
  endproperty
  // Controller keeps codes and data steady while a request is pending
  property p_mon_codes;
    monitor_request_bit && !monitor_valid_bit |=> $stable(first_monitor_code) && $stable(second_monitor_code);
  endproperty
  property p_ins_codes;
    instruction_request_bit && !instruction_complete_bit |=> $stable(instruction_select) && $stable(write_value);
  endproperty

  a_mv_cause: assert property (p_mv_cause) else $error("monitor valid without request");
  a_mv_hold: assert property (p_mv_hold) else $error("monitor valid dropped early");
  a_mv_drop: assert property (p_mv_drop) else $error("monitor valid stuck");
  a_ic_cause: assert property (p_ic_cause) else $error("complete without request");
  a_ic_drop: assert property (p_ic_drop) else $error("complete stuck");
  a_mv_time: assert property (p_mv_time) else $error("monitor answer late");
  a_ic_time: assert property (p_ic_time) else $error("instruction answer late");
  a_mv_words: assert property (p_mv_words) else $error("monitor words moved");
  a_mon_codes: assert property (p_mon_codes) else $error("monitor codes moved");
  a_ins_codes: assert property (p_ins_codes) else $error("instruction words moved");

  c_mon: cover property ($rose(monitor_valid_bit));
  c_ins: cover property ($rose(instruction_complete_bit));
  c_err: cover property ($rose(monitor_valid_bit) && response_status != 16'h0000);
endmodule : rwm_link_checker

// >>> dv/tb.sv
// Self-checking bench: AXI controller end, link, driver end and a behavioural source
`include "rwm_params.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic        two_station = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'h0;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  wire logic   s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq, stat_req, ins_req;
  wire logic [1:0]  s_axi_bresp, s_axi_rresp;
  wire logic [31:0] s_axi_rdata;
  wire logic [15:0] stat_code, ins_code, ins_wdata;
  logic        stat_ack = 0, stat_known = 0, stat_wide = 0, ins_ack = 0, ins_err = 0;
  logic [31:0] stat_data = 32'h0;
  logic [15:0] ins_rdata = 16'h0;
  integer      seed = 74, miscompares = 0, num_checks = 0, mi = 0, iw = -1;
  logic [31:0] md [2], rd, rv, sv;
  logic [15:0] sc [2], gc, gw, gr, c1, c2;
  logic [2:0]  msk = 3'h0;
  logic [1:0]  rr;
  bit          mk [2], mw [2], mon_bad, ins_bad;
  rwm_if link ();
  rwm_device i_rwm_device (.aclk, .aresetn, .link(link), .two_station, .stat_req, .stat_code, .stat_ack,
    .stat_known, .stat_wide, .stat_data, .ins_req, .ins_code, .ins_wdata, .ins_ack, .ins_err, .ins_rdata);
  rwm_host i_rwm_host (.aclk, .aresetn, .link(link), .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .irq);
  rwm_link_checker i_rwm_link_checker (.aclk, .aresetn, .first_monitor_code(link.first_monitor_code),
    .second_monitor_code(link.second_monitor_code), .instruction_select(link.instruction_select),
    .write_value(link.write_value), .monitor_request_bit(link.monitor_request_bit),
    .instruction_request_bit(link.instruction_request_bit), .monitor_result_word0(link.monitor_result_word0),
    .monitor_result_word1(link.monitor_result_word1), .response_status(link.response_status),
    .read_value(link.read_value), .second_monitor_low_half(link.second_monitor_low_half),
    .second_monitor_high_half(link.second_monitor_high_half), .monitor_valid_bit(link.monitor_valid_bit),
    .instruction_complete_bit(link.instruction_complete_bit));

  always #12.5 aclk = ~aclk;

  // Status source and instruction executor; the executor stalls a random 0..2 cycles
  always @(posedge aclk)
  begin
    stat_ack <= 1'b0;
    ins_ack  <= 1'b0;
    if (stat_req === 1'b1)
    begin
      rd = $random(seed);
      sc[mi] = stat_code;
      mk[mi] = (stat_code !== 16'hFFFF);
      mw[mi] = rd[4];
      md[mi] = rd;
      stat_ack   <= 1'b1;
      stat_known <= mk[mi];
      stat_wide  <= rd[4];
      stat_data  <= rd;
      mi = (mi + 1) % 2;
    end
    if (ins_req === 1'b1)
    begin
      gc = ins_code;
      gw = ins_wdata;
      gr = 16'($random(seed));
      iw = $unsigned($random(seed)) % 3;
    end
    else if (iw == 0)
    begin
      ins_ack   <= 1'b1;
      ins_err   <= (gc === 16'hFFFF);
      ins_rdata <= gr;
      iw = -1;
    end
    else if (iw > 0)
      iw--;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // AXI write: both channels offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_wstrb   <= 4'hF;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    forever
    begin
      @(posedge aclk);
      if (s_axi_awready && s_axi_awvalid) s_axi_awvalid <= 1'b0;
      if (s_axi_wready && s_axi_wvalid) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid && s_axi_bready)
      begin
        rr = s_axi_bresp;
        s_axi_bready <= 1'b0;
        break;
      end
    end
  endtask : wr

  task automatic rdr(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    forever
    begin
      @(posedge aclk);
      if (s_axi_arready && s_axi_arvalid) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid && s_axi_rready)
      begin
        rv = s_axi_rdata;
        rr = s_axi_rresp;
        s_axi_rready <= 1'b0;
        break;
      end
    end
  endtask : rdr

  // Poll the done bit; bounded so a lost handshake shows as a mismatch
  task automatic poll(input int b);
    int n;
    n = 0;
    sv = 32'h0;
    while (sv[b] !== 1'b1 && n < 60)
    begin
      rdr(8'h14);
      sv = rv;
      n++;
    end
    chk(sv[b], 1'b1);
  endtask : poll

  task automatic tail(input int b);
    chk(sv[2], mon_bad || ins_bad);
    rdr(8'h28);
    chk(rv, (mon_bad || ins_bad) ? {16'h0, `RWM_ERR_CODE} : 32'h0);
    chk(irq, msk[b]);
    wr(8'h14, 32'h7);
    @(posedge aclk);
    chk(irq, 1'b0);
  endtask : tail

  function automatic logic [15:0] hi(input int k);
    return mw[k] ? md[k][31:16] : {16{md[k][15]}};
  endfunction : hi

  task automatic mon(input logic two);
    logic [15:0] e [4];
    logic [7:0]  ofs [4];
    ofs = '{8'h20, 8'h24, 8'h30, 8'h34};
    two_station <= two;
    mi = 0;
    mk = '{1'b1, 1'b1};
    wr(8'h00, {16'h0, c1});
    wr(8'h04, {16'h0, c2});
    wr(8'h10, 32'h1);
    poll(0);
    chk(sc[0], c1);
    chk(sc[1], c2);
    mon_bad = !(mk[0] && mk[1]);
    e[0] = md[0][15:0];
    e[1] = two ? hi(0) : md[1][15:0];
    e[2] = two ? md[1][15:0] : 16'h0;
    e[3] = two ? hi(1) : 16'h0;
    foreach (e[k])
    begin
      rdr(ofs[k]);
      chk(rv, mon_bad ? 32'h0 : {16'h0, e[k]});
    end
    tail(0);
  endtask : mon

  task automatic ins(input logic [15:0] w);
    wr(8'h08, {16'h0, c1});
    wr(8'h0C, {16'h0, w});
    wr(8'h10, 32'h2);
    poll(1);
    chk(gc, c1);
    chk(gw, w);
    ins_bad = (c1 === 16'hFFFF);
    rdr(8'h2C);
    chk(rv, ins_bad ? 32'h0 : {16'h0, gr});
    tail(1);
  endtask : ins

  task automatic complete_run();
    if (miscompares == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : complete_run

  // Watchdog well beyond the expected run of about a thousand cycles
  initial
  begin
    repeat (20000) @(posedge aclk);
    miscompares++;
    complete_run();
  end

  // Main sequence: idle reads, unmapped access, then mixed monitor and instruction traffic
  initial
  begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rdr(8'h10);
    chk(rv, 32'h0);
    rdr(8'h14);
    chk(rv, 32'h0);
    rdr(8'h40);
    chk({rr, rv}, {2'b10, 32'h0});
    wr(8'h44, 32'h1);
    chk(rr, 2'b10);
    for (int t = 0; t < 12; t++)
    begin
      if (t == 6) wr(8'h18, 32'h3);
      msk = (t >= 6) ? 3'h3 : 3'h0;
      c1 = 16'($random(seed));
      c2 = 16'($random(seed));
      c1[15] = 1'b0;
      c2[15] = 1'b0;
      if (t % 3 == 1) c2 = 16'hFFFF;
      if (t % 3 == 2) c1 = 16'hFFFF;
      mon(t[1]);
      c1 = 16'($random(seed));
      c1[15] = 1'b0;
      if (t % 4 == 3) c1 = 16'hFFFF;
      ins(16'($random(seed)));
    end
    complete_run();
  end
endmodule : tb

// >>> hdl/rwm_device.sv
// Driver end: answers monitor and instruction requests over the remote words
`include "rwm_params.svh"
module rwm_device
  import rwm_pkg::*;
#(
  parameter logic [15:0] ERR_CODE = `RWM_ERR_CODE
)
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  rwm_if.dev               link,
  input  wire logic        two_station,
  output wire logic        stat_req,
  output wire logic [15:0] stat_code,
  input  wire logic        stat_ack,
  input  wire logic        stat_known,
  input  wire logic        stat_wide,
  input  wire logic [31:0] stat_data,
  output wire logic        ins_req,
  output wire logic [15:0] ins_code,
  output wire logic [15:0] ins_wdata,
  input  wire logic        ins_ack,
  input  wire logic        ins_err,
  input  wire logic [15:0] ins_rdata
);

  // A zero error code would look like success
  if (ERR_CODE == `RWM_ZERO16)
  begin : g_err_check
    $error("rwm_device: ERR_CODE must be nonzero");
  end

  rwm_dev_state_t s;
  rwm_dev_state_t next_s;

  // Upper word of a fetched item, sign filled when it is only 16 bits
  function automatic logic [15:0] upper_of(input logic wide, input logic [31:0] d);
    logic [15:0] r;
    if (wide)
    begin
      r = d[31:16];
    end
    else
    begin
      r = {16{d[15]}};
    end
    return r;
  endfunction : upper_of

  // Next state of the whole end
  always_comb
  begin
    next_s = s;
    next_s.stat_req = 1'b0;
    next_s.ins_req = 1'b0;

    // Dropped request withdraws its answer bit so a new one is seen afresh
    if (!link.monitor_request_bit)
    begin
      next_s.mvalid = 1'b0;
    end
    if (!link.instruction_request_bit)
    begin
      next_s.icomplete = 1'b0;
    end

    unique case (s.st)
      DEV_IDLE:
      begin
        // Monitor takes precedence; both are served one after the other
        if (link.monitor_request_bit && !s.mvalid)
        begin
          next_s.stat_req = 1'b1;
          next_s.stat_code = link.first_monitor_code;
          next_s.st = DEV_FETCH1;
        end
        else if (link.instruction_request_bit && !s.icomplete)
        begin
          next_s.ins_req = 1'b1;
          next_s.ins_code = link.instruction_select;
          next_s.ins_wdata = link.write_value;
          next_s.st = DEV_INSTR;
        end
      end

      DEV_FETCH1:
      begin
        // First item kept aside until the second is in hand
        if (stat_ack)
        begin
          next_s.t_err = !stat_known;
          next_s.t_lo = stat_data[15:0];
          next_s.t_hi = upper_of(stat_wide, stat_data);
          next_s.stat_req = 1'b1;
          next_s.stat_code = link.second_monitor_code;
          next_s.st = DEV_FETCH2;
        end
      end

      DEV_FETCH2:
      begin
        if (stat_ack)
        begin
          next_s.mon_err = s.t_err || !stat_known;
          if (s.t_err || !stat_known)
          begin
            next_s.w0 = `RWM_ZERO16;
            next_s.w1 = `RWM_ZERO16;
            next_s.w5 = `RWM_ZERO16;
            next_s.w6 = `RWM_ZERO16;
          end
          else if (two_station)
          begin
            next_s.w0 = s.t_lo;
            next_s.w1 = s.t_hi;
            next_s.w5 = stat_data[15:0];
            next_s.w6 = upper_of(stat_wide, stat_data);
          end
          else
          begin
            next_s.w0 = s.t_lo;
            next_s.w1 = stat_data[15:0];
            next_s.w5 = `RWM_ZERO16;
            next_s.w6 = `RWM_ZERO16;
          end
          // Words and valid change in one update
          next_s.mvalid = 1'b1;
          next_s.st = DEV_IDLE;
        end
      end

      DEV_INSTR:
      begin
        // Read data valid only on success
        if (ins_ack)
        begin
          next_s.ins_err = ins_err;
          if (ins_err)
          begin
            next_s.w3 = `RWM_ZERO16;
          end
          else
          begin
            next_s.w3 = ins_rdata;
          end
          next_s.icomplete = 1'b1;
          next_s.st = DEV_IDLE;
        end
      end
    endcase

    // Response word reflects the most recent outcome of both paths
    if (next_s.mon_err || next_s.ins_err)
    begin
      next_s.resp = ERR_CODE;
    end
    else
    begin
      next_s.resp = `RWM_ZERO16;
    end
  end

  // State register
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s <= '0;
      s.st <= DEV_IDLE;
    end
    else
    begin
      s <= next_s;
    end
  end

  // Link words straight from flops
  assign link.monitor_result_word0     = s.w0;
  assign link.monitor_result_word1     = s.w1;
  assign link.response_status          = s.resp;
  assign link.read_value               = s.w3;
  assign link.second_monitor_low_half  = s.w5;
  assign link.second_monitor_high_half = s.w6;
  assign link.monitor_valid_bit        = s.mvalid;
  assign link.instruction_complete_bit = s.icomplete;

  // User side requests
  assign stat_req  = s.stat_req;
  assign stat_code = s.stat_code;
  assign ins_req   = s.ins_req;
  assign ins_code  = s.ins_code;
  assign ins_wdata = s.ins_wdata;

endmodule : rwm_device

// >>> hdl/rwm_host.sv
// Controller end: AXI4-Lite registers driving the remote word handshakes
//
// Added by the designer: the AXI4-Lite register port and the placing of the registers.
`include "rwm_params.svh"
module rwm_host
  import rwm_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  rwm_if.host              link,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output wire logic        s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output wire logic        s_axi_wready,
  output wire logic [1:0]  s_axi_bresp,
  output wire logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output wire logic        s_axi_arready,
  output wire logic [31:0] s_axi_rdata,
  output wire logic [1:0]  s_axi_rresp,
  output wire logic        s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output wire logic        irq
);

  rwm_host_state_t s;
  rwm_host_state_t next_s;

  // Merge of the two low byte lanes into a 16-bit register
  function automatic logic [15:0] lanes(input logic [15:0] old, input logic [31:0] d, input logic [3:0] b);
    return {b[1] ? d[15:8] : old[15:8], b[0] ? d[7:0] : old[7:0]};
  endfunction : lanes

  always_comb
  begin
    logic [`RWM_STAT_W-1:0] set;
    logic [`RWM_STAT_W-1:0] clr;
    logic                   busy;
    set = '0;
    clr = '0;
    next_s = s;
    busy = (s.mon != HS_IDLE) || (s.ins != HS_IDLE);

    // Write channels taken in either order
    if (s_axi_awvalid && s.awready)
    begin
      next_s.aw_got = 1'b1;
      next_s.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s.wready)
    begin
      next_s.w_got = 1'b1;
      next_s.w_data = s_axi_wdata;
      next_s.w_strb = s_axi_wstrb;
    end
    if (s.bvalid && s_axi_bready)
    begin
      next_s.bvalid = 1'b0;
    end
    if (s.aw_got && s.w_got && !s.bvalid)
    begin
      next_s.aw_got = 1'b0;
      next_s.w_got = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = `RWM_RESP_OKAY;
      unique case ({s.aw_addr[7:2], 2'b00})
        // Codes frozen while a request is pending
        `RWM_OFS_CODE1: if (!busy) next_s.code1 = lanes(s.code1, s.w_data, s.w_strb);
        `RWM_OFS_CODE2: if (!busy) next_s.code2 = lanes(s.code2, s.w_data, s.w_strb);
        `RWM_OFS_INSTR: if (!busy) next_s.instr = lanes(s.instr, s.w_data, s.w_strb);
        `RWM_OFS_WDATA: if (!busy) next_s.wdata = lanes(s.wdata, s.w_data, s.w_strb);
        `RWM_OFS_CMD:
        begin
          if (s.w_strb[0] && s.w_data[`RWM_BIT_MON] && s.mon == HS_IDLE && s.ins == HS_IDLE)
          begin
            next_s.mon = HS_REQ;
          end
          else if (s.w_strb[0] && s.w_data[`RWM_BIT_INS] && s.mon == HS_IDLE && s.ins == HS_IDLE)
          begin
            next_s.ins = HS_REQ;
          end
        end
        `RWM_OFS_STATUS: if (s.w_strb[0]) clr = s.w_data[`RWM_STAT_W-1:0];
        `RWM_OFS_MASK:   if (s.w_strb[0]) next_s.mask = s.w_data[`RWM_STAT_W-1:0];
        `RWM_OFS_RES0, `RWM_OFS_RES1, `RWM_OFS_RESP, `RWM_OFS_READ, `RWM_OFS_RES5, `RWM_OFS_RES6:
          next_s.bresp = `RWM_RESP_OKAY;
        default: next_s.bresp = `RWM_RESP_SLVERR;
      endcase
    end

    // Read channel: one outstanding read
    if (s.rvalid && s_axi_rready)
    begin
      next_s.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s.arready)
    begin
      next_s.rvalid = 1'b1;
      next_s.rresp = `RWM_RESP_OKAY;
      unique case ({s_axi_araddr[7:2], 2'b00})
        `RWM_OFS_CODE1:  next_s.rdata = {16'h0000, s.code1};
        `RWM_OFS_CODE2:  next_s.rdata = {16'h0000, s.code2};
        `RWM_OFS_INSTR:  next_s.rdata = {16'h0000, s.instr};
        `RWM_OFS_WDATA:  next_s.rdata = {16'h0000, s.wdata};
        `RWM_OFS_CMD:    next_s.rdata = {30'h00000000, s.ins != HS_IDLE, s.mon != HS_IDLE};
        `RWM_OFS_STATUS: next_s.rdata = {29'h00000000, s.stat};
        `RWM_OFS_MASK:   next_s.rdata = {29'h00000000, s.mask};
        `RWM_OFS_RES0:   next_s.rdata = {16'h0000, s.res0};
        `RWM_OFS_RES1:   next_s.rdata = {16'h0000, s.res1};
        `RWM_OFS_RESP:   next_s.rdata = {16'h0000, s.resp};
        `RWM_OFS_READ:   next_s.rdata = {16'h0000, s.rdval};
        `RWM_OFS_RES5:   next_s.rdata = {16'h0000, s.res5};
        `RWM_OFS_RES6:   next_s.rdata = {16'h0000, s.res6};
        default:
        begin
          next_s.rdata = 32'h00000000;
          next_s.rresp = `RWM_RESP_SLVERR;
        end
      endcase
    end
    next_s.arready = !next_s.rvalid;

    // Monitor handshake: capture on valid, then wait for valid to fall
    unique case (s.mon)
      HS_IDLE: ;
      HS_REQ:
        if (link.monitor_valid_bit)
        begin
          next_s.res0 = link.monitor_result_word0;
          next_s.res1 = link.monitor_result_word1;
          next_s.res5 = link.second_monitor_low_half;
          next_s.res6 = link.second_monitor_high_half;
          next_s.resp = link.response_status;
          next_s.mon = HS_DROP;
        end
      HS_DROP:
        if (!link.monitor_valid_bit)
        begin
          set[`RWM_BIT_MON] = 1'b1;
          set[`RWM_BIT_ERR] = (s.resp != `RWM_ZERO16);
          next_s.mon = HS_IDLE;
        end
    endcase

    // Instruction handshake
    unique case (s.ins)
      HS_IDLE: ;
      HS_REQ:
        if (link.instruction_complete_bit)
        begin
          next_s.rdval = link.read_value;
          next_s.resp = link.response_status;
          next_s.ins = HS_DROP;
        end
      HS_DROP:
        if (!link.instruction_complete_bit)
        begin
          set[`RWM_BIT_INS] = 1'b1;
          set[`RWM_BIT_ERR] = (s.resp != `RWM_ZERO16);
          next_s.ins = HS_IDLE;
        end
    endcase

    // Sticky status: a new event wins over a same-cycle clear
    next_s.stat = (s.stat & ~clr) | set;
    next_s.irq = |(next_s.stat & next_s.mask);
    next_s.awready = !next_s.aw_got;
    next_s.wready = !next_s.w_got;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s <= '0;
      s.mon <= HS_IDLE;
      s.ins <= HS_IDLE;
    end
    else
    begin
      s <= next_s;
    end
  end

  // Link codes and bus outputs straight from flops; request bits decoded from the handshake states
  assign link.first_monitor_code      = s.code1;
  assign link.second_monitor_code     = s.code2;
  assign link.instruction_select      = s.instr;
  assign link.write_value             = s.wdata;
  assign link.monitor_request_bit     = (s.mon == HS_REQ);
  assign link.instruction_request_bit = (s.ins == HS_REQ);
  assign s_axi_awready = s.awready;
  assign s_axi_wready  = s.wready;
  assign s_axi_bvalid  = s.bvalid;
  assign s_axi_bresp   = s.bresp;
  assign s_axi_arready = s.arready;
  assign s_axi_rvalid  = s.rvalid;
  assign s_axi_rdata   = s.rdata;
  assign s_axi_rresp   = s.rresp;
  assign irq           = s.irq;

endmodule : rwm_host

// >>> hdl/rwm_if.sv
// Remote word registers and handshake bits between controller and driver
interface rwm_if;
  logic [15:0] first_monitor_code;
  logic [15:0] second_monitor_code;
  logic [15:0] instruction_select;
  logic [15:0] write_value;
  logic        monitor_request_bit;
  logic        instruction_request_bit;
  logic [15:0] monitor_result_word0;
  logic [15:0] monitor_result_word1;
  logic [15:0] response_status;
  logic [15:0] read_value;
  logic [15:0] second_monitor_low_half;
  logic [15:0] second_monitor_high_half;
  logic        monitor_valid_bit;
  logic        instruction_complete_bit;

  modport dev (
    input  first_monitor_code, second_monitor_code, instruction_select, write_value,
    input  monitor_request_bit, instruction_request_bit,
    output monitor_result_word0, monitor_result_word1, response_status, read_value,
    output second_monitor_low_half, second_monitor_high_half,
    output monitor_valid_bit, instruction_complete_bit
  );
  modport host (
    output first_monitor_code, second_monitor_code, instruction_select, write_value,
    output monitor_request_bit, instruction_request_bit,
    input  monitor_result_word0, monitor_result_word1, response_status, read_value,
    input  second_monitor_low_half, second_monitor_high_half,
    input  monitor_valid_bit, instruction_complete_bit
  );
endinterface : rwm_if

// >>> hdl/rwm_params.svh
// Constants of the remote word monitor and instruction link
`ifndef RWM_PARAMS_SVH
`define RWM_PARAMS_SVH
// Default nonzero error code of the response word
`define RWM_ERR_CODE     16'h0001
`define RWM_ZERO16       16'h0000
// Host register byte offsets
`define RWM_OFS_CODE1    8'h00
`define RWM_OFS_CODE2    8'h04
`define RWM_OFS_INSTR    8'h08
`define RWM_OFS_WDATA    8'h0C
`define RWM_OFS_CMD      8'h10
`define RWM_OFS_STATUS   8'h14
`define RWM_OFS_MASK     8'h18
`define RWM_OFS_RES0     8'h20
`define RWM_OFS_RES1     8'h24
`define RWM_OFS_RESP     8'h28
`define RWM_OFS_READ     8'h2C
`define RWM_OFS_RES5     8'h30
`define RWM_OFS_RES6     8'h34
// Command and status bit positions, status width and AXI response codes
`define RWM_BIT_MON      0
`define RWM_BIT_INS      1
`define RWM_BIT_ERR      2
`define RWM_STAT_W       3
`define RWM_RESP_OKAY    2'b00
`define RWM_RESP_SLVERR  2'b10
`endif

// >>> hdl/rwm_pkg.sv
// Types shared by both ends of the remote word link
`include "rwm_params.svh"
package rwm_pkg;
  typedef enum logic [1:0] {DEV_IDLE, DEV_FETCH1, DEV_FETCH2, DEV_INSTR} rwm_dev_st_t;
  typedef enum logic [1:0] {HS_IDLE, HS_REQ, HS_DROP} rwm_hs_t;

  typedef struct packed {
    rwm_dev_st_t st;
    logic [15:0] w0;
    logic [15:0] w1;
    logic [15:0] w3;
    logic [15:0] w5;
    logic [15:0] w6;
    logic [15:0] resp;
    logic        mon_err;
    logic        ins_err;
    logic        mvalid;
    logic        icomplete;
    logic        stat_req;
    logic [15:0] stat_code;
    logic        ins_req;
    logic [15:0] ins_code;
    logic [15:0] ins_wdata;
    logic [15:0] t_lo;
    logic [15:0] t_hi;
    logic        t_err;
  } rwm_dev_state_t;

  typedef struct packed {
    rwm_hs_t     mon;
    rwm_hs_t     ins;
    logic [15:0] code1;
    logic [15:0] code2;
    logic [15:0] instr;
    logic [15:0] wdata;
    logic [15:0] res0;
    logic [15:0] res1;
    logic [15:0] resp;
    logic [15:0] rdval;
    logic [15:0] res5;
    logic [15:0] res6;
    logic [`RWM_STAT_W-1:0] stat;
    logic [`RWM_STAT_W-1:0] mask;
    logic        irq;
    logic        aw_got;
    logic [7:0]  aw_addr;
    logic        w_got;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } rwm_host_state_t;
endpackage : rwm_pkg
